// ==== shared/eeprom_write_pkg.sv ====
package eeprom_write_pkg;
  localparam int ADDR_W = 15;                 // Byte address width
  localparam int COL_W = 6;                   // In-page column width
  localparam int PAGE_W = ADDR_W - COL_W;     // Page number width
  localparam int WORD_ADDR_W = ADDR_W - 2;    // Physical word address width
  localparam int DATA_W = 32;                 // Data bits per physical word
  localparam int CHK_W = 6;                   // Check bits per physical word
  localparam int PHYS_W = DATA_W + CHK_W;     // Stored word width, 38
  localparam int WORDS_PER_PAGE = 16;         // Physical words in one page
  localparam int ZONE_LSB = 12;               // Lowest address bit of zone number
  localparam int BITS_PER_BYTE = 8;           // Serial bits before the acknowledge slot
  localparam int PROG_CYCLES_DEF = 20000;     // Default program cycle length in clocks
  localparam int TIMER_W = 24;                // Program timer width
  localparam logic [3:0] DEV_TYPE = 4'ha;     // Array device type identifier
  localparam logic [3:0] CNT_ZERO = 4'h0;     // Bit counter start
  localparam logic [3:0] CNT_BYTE = 4'h8;     // Bit counter at byte end

  // Serial protocol states
  typedef enum logic [2:0] {S_IDLE, S_DEV, S_AHI, S_ALO, S_WDATA, S_RDATA} ser_state_e;

  // Program engine states
  typedef enum logic [1:0] {P_IDLE, P_WAIT, P_WORD, P_TIMER} prog_state_e;

  // One received data byte on its way to the page buffer
  typedef struct packed {
    logic [COL_W-1:0] col;
    logic [7:0] data;
  } page_entry_s;
endpackage : eeprom_write_pkg

// ==== src/i2c_eeprom_write_control.sv ====
`timescale 1ns/100ps

// Byte FIFO between the serial receiver and the page buffer
module byte_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];  // Entry storage
  logic [AW:0] wr_ptr_reg;           // Write pointer with wrap bit
  logic [AW:0] rd_ptr_reg;           // Read pointer with wrap bit
  wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire empty = (wr_ptr_reg == rd_ptr_reg);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = store[rd_ptr_reg[AW-1:0]];

  // Pointers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  // Entry write
  always_ff @(posedge ref_clk) begin
    if (push) store[wr_ptr_reg[AW-1:0]] <= in_data;
  end
endmodule : byte_fifo

// Serial client write, poll and standby control with ECC array
module i2c_eeprom_write_control
  import eeprom_write_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF,  // Program cycle length in clocks
  parameter int FIFO_DEPTH = 8                   // Receive FIFO depth
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Serial bus, data line split into three signals
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Straps and protection controls
  input wire logic [2:0] client_addr,
  input wire logic wp,
  input wire logic protect_scheme_select,
  input wire logic [7:0] zone_lock,
  // Status
  output logic standby,
  output logic prog_busy
);
  import eeprom_write_pkg::*;

  // Check bits for a 32-bit word, Hamming over positions 3..38
  function automatic logic [CHK_W-1:0] ecc_gen(input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] c;
    int i;
    c = '0;
    i = 0;
    for (int p = 3; p <= PHYS_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int k = 0; k < CHK_W; k++) begin
          if (p[k]) c[k] = c[k] ^ d[i];
        end
        i = i + 1;
      end
    end
    return c;
  endfunction : ecc_gen

  // Single-bit correction of a stored word
  function automatic logic [DATA_W-1:0] ecc_fix(input logic [PHYS_W-1:0] w);
    logic [DATA_W-1:0] d;
    logic [CHK_W-1:0] syn;
    int i;
    d = w[DATA_W-1:0];
    syn = w[PHYS_W-1:DATA_W] ^ ecc_gen(d);
    i = 0;
    for (int p = 3; p <= PHYS_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (syn == CHK_W'(p)) d[i] = ~d[i];
        i = i + 1;
      end
    end
    return d;
  endfunction : ecc_fix

  logic [PHYS_W-1:0] array_mem [2**WORD_ADDR_W];  // Physical words
  logic [7:0] pg_data [2**COL_W];                 // Page buffer bytes
  logic [2**COL_W-1:0] pg_valid_reg;             // Page buffer byte marks
  logic scl_reg, sda_reg;                         // Previous line samples
  ser_state_e state_reg;                          // Serial state
  logic [3:0] cnt_reg;                            // Bits in current byte
  logic [7:0] shift_reg;                          // Byte shifter
  logic ack_ph_reg;                               // In acknowledge slot
  logic oe_reg;                                   // Data line pulled low
  logic [ADDR_W-1:0] ptr_reg;                     // Byte address pointer
  logic got_data_reg;                             // Data byte taken this transfer
  prog_state_e pstate_reg;                        // Program engine state
  logic [3:0] widx_reg;                           // Word index in page
  logic [TIMER_W-1:0] timer_reg;                  // Program timer

  // Bus condition decode on synchronous samples
  wire start_evt = scl && scl_reg && sda_reg && !sda_i;
  wire stop_evt = scl && scl_reg && !sda_reg && sda_i;
  wire scl_rise = scl && !scl_reg;
  wire scl_fall = !scl && scl_reg;
  wire byte_end = scl_fall && !ack_ph_reg && (cnt_reg == CNT_BYTE);
  wire slot_end = scl_fall && ack_ph_reg;
  wire busy = (pstate_reg != P_IDLE);
  wire addr_match = (shift_reg[7:4] == DEV_TYPE) && (shift_reg[3:1] == client_addr);

  // FIFO hookup
  page_entry_s push_entry, pop_entry;
  logic fifo_in_ready, fifo_out_valid;
  wire drain_ready = (pstate_reg == P_IDLE) || (pstate_reg == P_WAIT);
  wire push_req = byte_end && (state_reg == S_WDATA);
  wire drain = fifo_out_valid && drain_ready;
  assign push_entry = '{col: ptr_reg[COL_W-1:0], data: shift_reg};

  byte_fifo #(.WIDTH($bits(page_entry_s)), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(push_req),
    .in_ready(fifo_in_ready),
    .in_data(push_entry),
    .out_valid(fifo_out_valid),
    .out_ready(drain_ready),
    .out_data(pop_entry)
  );

  // Read data path with correction
  wire [DATA_W-1:0] rd_word = ecc_fix(array_mem[ptr_reg[ADDR_W-1:2]]);
  wire [7:0] rd_byte = rd_word[ptr_reg[1:0]*8 +: 8];

  // Program word merge: untouched bytes kept, checks recomputed
  wire [WORD_ADDR_W-1:0] pw_addr = {ptr_reg[ADDR_W-1:COL_W], widx_reg};
  wire [DATA_W-1:0] old_word = ecc_fix(array_mem[pw_addr]);
  wire [3:0] pw_mask = pg_valid_reg[widx_reg*4 +: 4];
  logic [DATA_W-1:0] new_word;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      new_word[b*8 +: 8] = pw_mask[b] ? pg_data[{widx_reg, 2'(b)}] : old_word[b*8 +: 8];
    end
  end

  // Protection check at the stop
  wire zone_hit = zone_lock[ptr_reg[ZONE_LSB +: 3]];
  wire protected_now = protect_scheme_select ? zone_hit : wp;

  // Serial next state
  ser_state_e state_next;
  logic [3:0] cnt_next;
  logic [7:0] shift_next;
  logic ack_ph_next, oe_next, got_data_next;
  logic [ADDR_W-1:0] ptr_next;
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    ack_ph_next = ack_ph_reg;
    oe_next = oe_reg;
    ptr_next = ptr_reg;
    got_data_next = got_data_reg;
    if (start_evt) begin
      // Every transfer opens here, also after recovery
      state_next = S_DEV;
      cnt_next = CNT_ZERO;
      ack_ph_next = 1'b0;
      oe_next = 1'b0;
      got_data_next = 1'b0;
    end else if (stop_evt) begin
      state_next = S_IDLE;
      cnt_next = CNT_ZERO;
      ack_ph_next = 1'b0;
      oe_next = 1'b0;
    end else if (state_reg != S_IDLE) begin
      if (scl_rise && !ack_ph_reg && (cnt_reg < CNT_BYTE)) begin
        // Take one bit
        if (state_reg != S_RDATA) shift_next = {shift_reg[6:0], sda_i};
        cnt_next = cnt_reg + 4'h1;
      end else if (scl_rise && ack_ph_reg && (state_reg == S_RDATA) && !oe_reg) begin
        // Host answer on a read byte
        if (sda_i) begin
          state_next = S_IDLE;
        end else begin
          ptr_next = ptr_reg + 1'b1;
        end
      end else if (byte_end) begin
        ack_ph_next = 1'b1;
        unique case (state_reg)
          S_DEV: begin
            // No answer while programming or on mismatch
            if (addr_match && !busy) begin
              oe_next = 1'b1;
              state_next = shift_reg[0] ? S_RDATA : S_AHI;
            end else begin
              state_next = S_IDLE;
            end
          end
          S_AHI: begin
            oe_next = 1'b1;
            ptr_next = {shift_reg[ADDR_W-9:0], ptr_reg[7:0]};
            state_next = S_ALO;
          end
          S_ALO: begin
            oe_next = 1'b1;
            ptr_next = {ptr_reg[ADDR_W-1:8], shift_reg};
            state_next = S_WDATA;
          end
          S_WDATA: begin
            // Byte taken only when the FIFO has room
            oe_next = fifo_in_ready;
            if (fifo_in_ready) begin
              got_data_next = 1'b1;
              ptr_next = {ptr_reg[ADDR_W-1:COL_W], ptr_reg[COL_W-1:0] + 1'b1};
            end
          end
          S_RDATA: oe_next = 1'b0;
          default: state_next = S_IDLE;
        endcase
      end else if (slot_end) begin
        // Release the line after the slot; in a read, drive the first bit of the next byte
        ack_ph_next = 1'b0;
        cnt_next = CNT_ZERO;
        oe_next = 1'b0;
        if (state_reg == S_RDATA) begin
          shift_next = rd_byte;
          oe_next = !rd_byte[7];
        end
      end else if (scl_fall && (state_reg == S_RDATA) && (cnt_reg < CNT_BYTE)) begin
        // Next read bit
        oe_next = !shift_reg[3'(7 - cnt_reg)];
      end
    end
  end

  // Serial registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      state_reg <= S_IDLE;
      cnt_reg <= CNT_ZERO;
      shift_reg <= '0;
      ack_ph_reg <= 1'b0;
      oe_reg <= 1'b0;
      ptr_reg <= '0;
      got_data_reg <= 1'b0;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda_i;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      ack_ph_reg <= ack_ph_next;
      oe_reg <= oe_next;
      ptr_reg <= ptr_next;
      got_data_reg <= got_data_next;
    end
  end

  // Program request: stop after data in a write transfer
  wire prog_req = stop_evt && (state_reg == S_WDATA) && got_data_reg;
  wire timer_done = (timer_reg == TIMER_W'(PROG_CYCLES - 1));
  wire clear_page = (pstate_reg == P_TIMER) && timer_done;

  // Program engine, untouched by serial restarts
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pstate_reg <= P_IDLE;
      widx_reg <= '0;
      timer_reg <= '0;
    end else begin
      unique case (pstate_reg)
        P_IDLE: begin
          if (prog_req && !protected_now) pstate_reg <= P_WAIT;
          widx_reg <= '0;
          timer_reg <= '0;
        end
        P_WAIT: if (!fifo_out_valid) pstate_reg <= P_WORD;
        P_WORD: begin
          widx_reg <= widx_reg + 4'h1;
          if (widx_reg == 4'(WORDS_PER_PAGE - 1)) pstate_reg <= P_TIMER;
        end
        P_TIMER: begin
          timer_reg <= timer_reg + 1'b1;
          if (timer_done) pstate_reg <= P_IDLE;
        end
      endcase
    end
  end

  // Page buffer marks: set by drain, cleared at program end, skip or a new start while not programming
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pg_valid_reg <= '0;
    end else if (drain) begin
      pg_valid_reg[pop_entry.col] <= 1'b1;
    end else if (clear_page || (prog_req && protected_now) || (start_evt && !busy)) begin
      pg_valid_reg <= '0;
    end
  end

  // Page buffer bytes and array words
  always_ff @(posedge ref_clk) begin
    if (drain) pg_data[pop_entry.col] <= pop_entry.data;
    if ((pstate_reg == P_WORD) && (pw_mask != 4'h0)) begin
      array_mem[pw_addr] <= {ecc_gen(new_word), new_word};
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = oe_reg;
  assign prog_busy = busy;
  assign standby = (state_reg == S_IDLE) && !busy;
endmodule : i2c_eeprom_write_control

// ==== test/i2c_eeprom_write_control_props.sv ====
`timescale 1ns/100ps
// Port checks of the serial write controller
module i2c_eeprom_write_control_props
  import eeprom_write_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Serial bus
  input wire logic scl,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Straps and protection
  input wire logic [2:0] client_addr,
  input wire logic wp,
  input wire logic protect_scheme_select,
  input wire logic [7:0] zone_lock,
  // Status
  input wire logic standby,
  input wire logic prog_busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [TIMER_W-1:0] busy_cnt_reg; // Busy cycles so far
  logic [3:0] fall_cnt_reg; // Clock falls while data held low
  logic scl_reg; // Previous clock sample
  // Helper counters
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt_reg <= '0;
      fall_cnt_reg <= 4'h0;
      scl_reg <= 1'b1;
    end else begin
      busy_cnt_reg <= prog_busy ? busy_cnt_reg + 1'b1 : '0;
      fall_cnt_reg <= sda_oe ? fall_cnt_reg + {3'h0, scl_reg & ~scl} : 4'h0;
      scl_reg <= scl;
    end
  end
  property p_busy_no_ack; prog_busy |-> !sda_oe; endproperty
  a_busy_no_ack: assert property (p_busy_no_ack) else $error("ack while busy");
  property p_busy_not_idle; prog_busy |-> !standby; endproperty
  a_busy_not_idle: assert property (p_busy_not_idle) else $error("idle while busy");
  property p_end_idle; $fell(prog_busy) |-> standby; endproperty
  a_end_idle: assert property (p_end_idle) else $error("no idle at program end");
  property p_oe_rise; $rose(sda_oe) |-> !scl && !prog_busy; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("bad drive start");
  property p_release_nine; fall_cnt_reg <= 4'h9; endproperty
  a_release_nine: assert property (p_release_nine) else $error("data held too long");
  property p_open_drain; sda_oe |-> sda_o == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("data driven high");
  property p_busy_min; $fell(prog_busy) |-> busy_cnt_reg >= PROG_CYCLES; endproperty
  a_busy_min: assert property (p_busy_min) else $error("program too short");
  property p_busy_max; busy_cnt_reg <= PROG_CYCLES + 100; endproperty
  a_busy_max: assert property (p_busy_max) else $error("program too long");
  property p_busy_at_stop; $rose(prog_busy) |-> $past(scl) && $past(sda_i); endproperty
  a_busy_at_stop: assert property (p_busy_at_stop) else $error("program not at stop");
  c_prog: cover property ($rose(prog_busy));
  c_ack: cover property ($rose(sda_oe));
  c_done: cover property ($fell(prog_busy));
endmodule : i2c_eeprom_write_control_props

bind i2c_eeprom_write_control i2c_eeprom_write_control_props #(.PROG_CYCLES(PROG_CYCLES), .FIFO_DEPTH(FIFO_DEPTH))
  u_props (.ref_clk(ref_clk), .rst_b(rst_b), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .client_addr(client_addr), .wp(wp), .protect_scheme_select(protect_scheme_select), .zone_lock(zone_lock),
  .standby(standby), .prog_busy(prog_busy));

// ==== test/host_model.sv ====
`timescale 1ns/100ps
// Host bus controller; lines change only at falling clock edges
module host_model (
  // Clock
  input wire logic ref_clk,
  // Bus
  output logic scl,
  output logic sda_h,
  input wire logic sda_i
);
  int hp = 4; // Half bit period in clocks
  // Bus idle with both lines high
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  // Wait n falling edges
  task automatic gap(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : gap
  // One pulse; data set while clock low, sampled at end of high
  task automatic bit_io(input logic b, output logic r);
    gap(1);
    sda_h = b;
    gap(hp);
    scl = 1'b1;
    gap(hp);
    r = sda_i;
    scl = 1'b0;
  endtask : bit_io
  // Start or repeated start
  task automatic start();
    gap(1);
    sda_h = 1'b1;
    gap(hp);
    scl = 1'b1;
    gap(hp);
    sda_h = 1'b0;
    gap(hp);
    scl = 1'b0;
  endtask : start
  // Stop: data rises while the clock is high
  task automatic stop();
    gap(1);
    sda_h = 1'b0;
    gap(hp);
    scl = 1'b1;
    gap(hp);
    sda_h = 1'b1;
    gap(hp);
  endtask : stop
  // Send a byte MSB first, return the acknowledge
  task automatic wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wr
  // Take a byte, then acknowledge or refuse it
  task automatic rd(input logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(nack, r);
  endtask : rd
endmodule : host_model

// ==== test/tb.sv ====
`timescale 1ns/100ps
// Self-checking bench for the serial write controller
module tb;
  import eeprom_write_pkg::*;
  localparam int PROG_T = 3000; // Shortened program time
  localparam logic [2:0] CA = 3'h5; // Strapped client address
  logic ref_clk = 1'b0;
  logic rst_b, wp, protect_scheme_select, standby, prog_busy;
  logic scl, sda_h, sda_i, sda_o, sda_oe;
  logic [2:0] client_addr;
  logic [7:0] zone_lock;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  // Open-drain data line with pull-up
  assign sda_i = sda_h & ~(sda_oe & ~sda_o);
  always #2 ref_clk = ~ref_clk;
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      give_verdict();
    end
  end
  host_model h (.ref_clk(ref_clk), .scl(scl), .sda_h(sda_h), .sda_i(sda_i));
  i2c_eeprom_write_control #(.PROG_CYCLES(PROG_T), .FIFO_DEPTH(8)) uut (.ref_clk(ref_clk), .rst_b(rst_b),
    .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .client_addr(client_addr), .wp(wp),
    .protect_scheme_select(protect_scheme_select), .zone_lock(zone_lock), .standby(standby), .prog_busy(prog_busy));
  // Byte compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Flag compare
  task automatic chkf(input logic g, input logic e);
    chk({7'h0, g}, {7'h0, e});
  endtask : chkf
  // Write address and both pointer bytes
  task automatic set_ptr(input logic [14:0] a);
    logic ack;
    h.start();
    h.wr({DEV_TYPE, CA, 1'b0}, ack);
    chkf(ack, 1'b1);
    h.wr({1'b0, a[14:8]}, ack);
    chkf(ack, 1'b1);
    h.wr(a[7:0], ack);
    chkf(ack, 1'b1);
  endtask : set_ptr
  // Write n bytes counting up from d0, then stop
  task automatic wr_page(input logic [14:0] a, input int n, input logic [7:0] d0);
    logic ack;
    set_ptr(a);
    for (int i = 0; i < n; i++) begin
      h.wr(d0 + 8'(i), ack);
      chkf(ack, 1'b1);
    end
    chkf(prog_busy, 1'b0);
    h.stop();
    h.gap(2);
  endtask : wr_page
  // Bounded wait for the program cycle to end
  task automatic wait_done();
    for (int i = 0; i < PROG_T + 200 && prog_busy !== 1'b0; i++) h.gap(1);
    chkf(prog_busy, 1'b0);
  endtask : wait_done
  // Random read; host refuses the last byte
  task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp [$]);
    logic ack;
    logic [7:0] b;
    set_ptr(a);
    h.start();
    h.wr({DEV_TYPE, CA, 1'b1}, ack);
    chkf(ack, 1'b1);
    foreach (exp[i]) begin
      h.rd(i == exp.size() - 1, b);
      chk(b, exp[i]);
    end
    h.gap(3);
    chkf(standby, 1'b1);
    h.stop();
  endtask : rd_chk
  // Single byte with slow polling
  task automatic t_byte();
    logic ack;
    wr_page(15'h0123, 1, 8'h3c);
    chkf(prog_busy, 1'b1);
    h.hp = 125;
    h.start();
    h.wr({DEV_TYPE, CA, 1'b0}, ack);
    chkf(ack, 1'b0);
    wait_done();
    h.start();
    h.wr({DEV_TYPE, CA, 1'b0}, ack);
    chkf(ack, 1'b1);
    h.stop();
    h.hp = 4;
    chkf(standby, 1'b1);
    rd_chk(15'h0123, '{8'h3c});
  endtask : t_byte
  // Page write over the page end, then one byte of a word rewritten
  task automatic t_page();
    wr_page(15'h12bc, 8, 8'h40);
    wait_done();
    rd_chk(15'h12bc, '{8'h40, 8'h41, 8'h42, 8'h43});
    rd_chk(15'h1280, '{8'h44, 8'h45, 8'h46, 8'h47});
    wr_page(15'h1281, 1, 8'h99);
    wait_done();
    rd_chk(15'h1280, '{8'h44, 8'h99, 8'h46, 8'h47});
  endtask : t_page
  // Pin high, zone locked, zone open with pin high
  task automatic t_protect();
    for (int i = 0; i < 3; i++) begin
      protect_scheme_select = (i != 0);
      wp = (i != 1);
      zone_lock = (i == 2) ? 8'hfd : 8'h02;
      wr_page(15'h1282, 1, 8'h70 + 8'(i));
      chkf(prog_busy, i == 2);
      wait_done();
      rd_chk(15'h1282, '{(i == 2) ? 8'h72 : 8'h46});
    end
    // Back to the open pin scheme so later writes are not blocked
    wp = 1'b0;
    protect_scheme_select = 1'b0;
  endtask : t_protect
  // Wrong type, wrong client address, then moved straps
  task automatic t_bad();
    logic ack;
    for (int i = 0; i < 3; i++) begin
      client_addr = (i == 2) ? CA ^ 3'h2 : CA;
      h.start();
      h.wr(i == 0 ? {4'hb, CA, 1'b0} : {DEV_TYPE, (i == 1) ? CA ^ 3'h1 : CA, 1'b0}, ack);
      chkf(ack, 1'b0);
      h.gap(3);
      chkf(standby, 1'b1);
      h.stop();
    end
    client_addr = CA;
  endtask : t_bad
  // Dummy clocks during programming and in mid-read
  task automatic t_rec();
    logic ack;
    logic r;
    int n;
    wr_page(15'h2000, 1, 8'h00);
    for (int i = 0; i < 9; i++) h.bit_io(1'b1, r);
    chkf(prog_busy, 1'b1);
    wait_done();
    set_ptr(15'h2000);
    h.start();
    h.wr({DEV_TYPE, CA, 1'b1}, ack);
    for (n = 0; n < 3; n++) h.bit_io(1'b1, r);
    r = 1'b0;
    for (n = 0; n < 12 && !r; n++) h.bit_io(1'b1, r);
    chkf(n <= 9, 1'b1);
    h.stop();
    rd_chk(15'h2000, '{8'h00});
  endtask : t_rec
  // Counts and verdict
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // Reset, then the scenarios
  initial begin
    rst_b = 1'b0;
    wp = 1'b0;
    protect_scheme_select = 1'b0;
    zone_lock = 8'h00;
    client_addr = CA;
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    h.gap(2);
    chkf(standby, 1'b1);
    t_byte();
    t_page();
    t_protect();
    t_bad();
    t_rec();
    give_verdict();
  end
endmodule : tb
